// File: common/timer_pkg.sv
/*
 * Shared constants for the dual legacy counter/timer: register indices,
 * field positions, mode codes, bus response codes and reset values.
 * Assumes nothing of its surroundings; included by package scope only.
 */
package timer_pkg;

    // Bus address width; byte address is four times the register index
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_TIMER_RUN_AND_FLAG_CONTROL = 10'h088;
    localparam logic [IDX_W-1:0] IDX_TIMER_MODE_SELECT_REGISTER = 10'h089;
    localparam logic [IDX_W-1:0] IDX_ZERO_COUNT_LOW_BYTE = 10'h08a;
    localparam logic [IDX_W-1:0] IDX_ONE_COUNT_LOW_BYTE = 10'h08b;
    localparam logic [IDX_W-1:0] IDX_ZERO_COUNT_HIGH_BYTE = 10'h08c;
    localparam logic [IDX_W-1:0] IDX_ONE_COUNT_HIGH_BYTE = 10'h08d;
    localparam logic [IDX_W-1:0] IDX_CLOCK_CHOICE_REGISTER = 10'h08e;
    localparam logic [IDX_W-1:0] IDX_EXT_INTERRUPT_CONFIG_REGISTER = 10'h08f;
    localparam logic [IDX_W-1:0] IDX_TIMER_INTERRUPT_ENABLE = 10'h090;

    // Run and flag control bits
    localparam int TC_ONE_OVERFLOW = 7;
    localparam int TC_ONE_RUN = 6;
    localparam int TC_ZERO_OVERFLOW = 5;
    localparam int TC_ZERO_RUN = 4;
    localparam int TC_EXT1_FLAG = 3;
    localparam int TC_EXT1_TYPE = 2;
    localparam int TC_EXT0_FLAG = 1;
    localparam int TC_EXT0_TYPE = 0;

    // Mode select fields
    localparam int TM_ONE_GATE = 7;
    localparam int TM_ONE_COUNTER_SELECT = 6;
    localparam int TM_ONE_MODE_MSB = 5;
    localparam int TM_ONE_MODE_LSB = 4;
    localparam int TM_ZERO_GATE = 3;
    localparam int TM_ZERO_COUNTER_SELECT = 2;
    localparam int TM_ZERO_MODE_MSB = 1;
    localparam int TM_ZERO_MODE_LSB = 0;

    // Clock choice, polarity and interrupt enable bits
    localparam int CK_ZERO = 0;
    localparam int CK_ONE = 1;
    localparam int PL_ZERO = 0;
    localparam int PL_ONE = 1;
    localparam int IEN_ZERO = 0;
    localparam int IEN_ONE = 1;

    // Mode codes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Top bit of the five-bit low field in the 13-bit mode
    localparam int LOW13_MSB = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] PAIR_RESET = 2'h0;

endpackage

// File: src/timer_core.sv
/*
 * Count step of one 16-bit counter/timer: next low and high bytes and the
 * overflow events for the selected mode. Purely combinational.
 * Assumes the caller registers the outputs and qualifies the ticks.
 */
`timescale 1ns/10ps
module timer_core #(
    parameter bit SPLIT_CAPABLE = 1'b1
) (
    input wire logic [1:0] mode,
    input wire logic tick,
    input wire logic hi_tick,
    input wire logic [7:0] low_in,
    input wire logic [7:0] high_in,
    output logic [7:0] low_out,
    output logic [7:0] high_out,
    output logic ovf,
    output logic hi_ovf
);

    logic [12:0] c13;
    logic [12:0] c13_inc;
    logic [15:0] c16;
    logic [15:0] c16_inc;

    always_comb begin
        c13 = {high_in, low_in[timer_pkg::LOW13_MSB:0]};
        c13_inc = 13'(c13 + 13'h0001);
        c16 = {high_in, low_in};
        c16_inc = 16'(c16 + 16'h0001);
        low_out = low_in;
        high_out = high_in;
        ovf = 1'b0;
        hi_ovf = 1'b0;
        case (mode)
            timer_pkg::MODE_13BIT: begin
                if (tick) begin
                    // Upper three low bits are left alone; software masks them
                    low_out[timer_pkg::LOW13_MSB:0] = c13_inc[timer_pkg::LOW13_MSB:0];
                    high_out = c13_inc[12:timer_pkg::LOW13_MSB+1];
                    ovf = &c13;
                end
            end
            timer_pkg::MODE_16BIT: begin
                if (tick) begin
                    {high_out, low_out} = c16_inc;
                    ovf = &c16;
                end
            end
            timer_pkg::MODE_RELOAD: begin
                if (tick) begin
                    // High byte is the reload source and never changes here
                    low_out = (&low_in) ? high_in : 8'(low_in + 8'h01);
                    ovf = &low_in;
                end
            end
            timer_pkg::MODE_SPLIT: begin
                // A timer without split support stays inactive
                if (SPLIT_CAPABLE) begin
                    if (tick) begin
                        low_out = 8'(low_in + 8'h01);
                        ovf = &low_in;
                    end
                    if (hi_tick) begin
                        high_out = 8'(high_in + 8'h01);
                        hi_ovf = &high_in;
                    end
                end
            end
            default: begin
                low_out = low_in;
            end
        endcase
    end

endmodule

// File: src/dual_legacy_counter_timer.sv
/*
 * Two legacy counter/timers with run/flag control, mode select, clock
 * choice, external interrupt polarity and timer interrupt enable registers,
 * reached over an AXI4-Lite slave.
 * Assumes count, gate and acknowledge inputs are synchronous to mclk and
 * that prescale_tick is a one-cycle pulse from an outside prescaler.
 */
`timescale 1ns/10ps

module dual_legacy_counter_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [timer_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [timer_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic zero_count_pin,
    input wire logic one_count_pin,
    input wire logic ext_gate_input_zero,
    input wire logic ext_gate_input_one,
    input wire logic prescale_tick,
    input wire logic zero_vector_ack,
    input wire logic one_vector_ack,
    input wire logic ext0_vector_ack,
    input wire logic ext1_vector_ack,
    output logic zero_irq,
    output logic one_irq,
    output logic ext0_irq,
    output logic ext1_irq,
    output logic one_overflow_pulse
);

    typedef struct packed {
        logic [7:0] timer_run_and_flag_control;
        logic [7:0] timer_mode_select_register;
        logic [7:0] zero_count_low_byte;
        logic [7:0] zero_count_high_byte;
        logic [7:0] one_count_low_byte;
        logic [7:0] one_count_high_byte;
        logic [1:0] clock_choice_register;
        logic [1:0] ext_interrupt_config_register;
        logic [1:0] timer_interrupt_enable;
        logic zero_pin_prev;
        logic one_pin_prev;
        logic ext0_active_prev;
        logic ext1_active_prev;
        logic aw_held;
        logic w_held;
        logic [timer_pkg::IDX_W-1:0] wr_index;
        logic [7:0] wr_byte;
        logic wr_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic zero_irq;
        logic one_irq;
        logic ext0_irq;
        logic ext1_irq;
        logic one_overflow_pulse;
    } state_t;

    localparam state_t STATE_RESET = '{
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        default: '0
    };

    state_t state_reg;
    state_t state_next;

    logic split;
    logic ext0_active;
    logic ext1_active;
    logic zero_fall;
    logic one_fall;
    logic zero_source;
    logic one_source;
    logic zero_enable;
    logic one_enable;
    logic zero_tick;
    logic one_tick;
    logic zero_hi_tick;
    logic [7:0] c0_low;
    logic [7:0] c0_high;
    logic c0_ovf;
    logic c0_hi_ovf;
    logic [7:0] c1_low;
    logic [7:0] c1_high;
    logic c1_ovf;
    logic c1_hi_ovf;
    logic set_zero_flag;
    logic set_one_flag;
    logic set_ext0;
    logic set_ext1;
    logic wr_fire;

    function automatic logic mapped(input logic [timer_pkg::IDX_W-1:0] idx);
        logic hit;
        hit = (idx >= timer_pkg::IDX_TIMER_RUN_AND_FLAG_CONTROL) && (idx <= timer_pkg::IDX_TIMER_INTERRUPT_ENABLE);
        return hit;
    endfunction

    function automatic logic [7:0] read_byte(input logic [timer_pkg::IDX_W-1:0] idx, input state_t st);
        logic [7:0] v;
        v = timer_pkg::BYTE_RESET;
        case (idx)
            timer_pkg::IDX_TIMER_RUN_AND_FLAG_CONTROL: v = st.timer_run_and_flag_control;
            timer_pkg::IDX_TIMER_MODE_SELECT_REGISTER: v = st.timer_mode_select_register;
            timer_pkg::IDX_ZERO_COUNT_LOW_BYTE: v = st.zero_count_low_byte;
            timer_pkg::IDX_ONE_COUNT_LOW_BYTE: v = st.one_count_low_byte;
            timer_pkg::IDX_ZERO_COUNT_HIGH_BYTE: v = st.zero_count_high_byte;
            timer_pkg::IDX_ONE_COUNT_HIGH_BYTE: v = st.one_count_high_byte;
            timer_pkg::IDX_CLOCK_CHOICE_REGISTER: v = {6'h00, st.clock_choice_register};
            timer_pkg::IDX_EXT_INTERRUPT_CONFIG_REGISTER: v = {6'h00, st.ext_interrupt_config_register};
            timer_pkg::IDX_TIMER_INTERRUPT_ENABLE: v = {6'h00, st.timer_interrupt_enable};
            default: v = timer_pkg::BYTE_RESET;
        endcase
        return v;
    endfunction

    timer_core #(
        .SPLIT_CAPABLE(1'b1)
    ) zero_core (
        .mode(state_reg.timer_mode_select_register[timer_pkg::TM_ZERO_MODE_MSB:timer_pkg::TM_ZERO_MODE_LSB]),
        .tick(zero_tick),
        .hi_tick(zero_hi_tick),
        .low_in(state_reg.zero_count_low_byte),
        .high_in(state_reg.zero_count_high_byte),
        .low_out(c0_low),
        .high_out(c0_high),
        .ovf(c0_ovf),
        .hi_ovf(c0_hi_ovf)
    );

    // Timer one has no split form; mode three leaves it idle
    timer_core #(
        .SPLIT_CAPABLE(1'b0)
    ) one_core (
        .mode(state_reg.timer_mode_select_register[timer_pkg::TM_ONE_MODE_MSB:timer_pkg::TM_ONE_MODE_LSB]),
        .tick(one_tick),
        .hi_tick(1'b0),
        .low_in(state_reg.one_count_low_byte),
        .high_in(state_reg.one_count_high_byte),
        .low_out(c1_low),
        .high_out(c1_high),
        .ovf(c1_ovf),
        .hi_ovf(c1_hi_ovf)
    );

    always_comb begin
        state_next = state_reg;
        split = state_reg.timer_mode_select_register[timer_pkg::TM_ZERO_MODE_MSB:timer_pkg::TM_ZERO_MODE_LSB]
            == timer_pkg::MODE_SPLIT;
        // Polarity bit one means active high
        ext0_active = ext_gate_input_zero == state_reg.ext_interrupt_config_register[timer_pkg::PL_ZERO];
        ext1_active = ext_gate_input_one == state_reg.ext_interrupt_config_register[timer_pkg::PL_ONE];
        zero_fall = state_reg.zero_pin_prev & ~zero_count_pin;
        one_fall = state_reg.one_pin_prev & ~one_count_pin;
        zero_source = state_reg.timer_mode_select_register[timer_pkg::TM_ZERO_COUNTER_SELECT] ? zero_fall
            : (state_reg.clock_choice_register[timer_pkg::CK_ZERO] | prescale_tick);
        // Split mode takes the external pin away from timer one
        one_source = (state_reg.timer_mode_select_register[timer_pkg::TM_ONE_COUNTER_SELECT] & ~split) ? one_fall
            : (state_reg.clock_choice_register[timer_pkg::CK_ONE] | prescale_tick);
        zero_enable = state_reg.timer_run_and_flag_control[timer_pkg::TC_ZERO_RUN]
            & (~state_reg.timer_mode_select_register[timer_pkg::TM_ZERO_GATE] | ext0_active);
        // Run bit belongs to the split high counter; mode three alone stops timer one
        one_enable = split ? 1'b1
            : state_reg.timer_run_and_flag_control[timer_pkg::TC_ONE_RUN]
            & (~state_reg.timer_mode_select_register[timer_pkg::TM_ONE_GATE] | ext1_active);
        zero_tick = zero_enable & zero_source;
        one_tick = one_enable & one_source;
        zero_hi_tick = state_reg.timer_run_and_flag_control[timer_pkg::TC_ONE_RUN]
            & (state_reg.clock_choice_register[timer_pkg::CK_ZERO] | prescale_tick);

        // Counting only moves the count; run bit edges never clear it
        state_next.zero_count_low_byte = c0_low;
        state_next.zero_count_high_byte = c0_high;
        state_next.one_count_low_byte = c1_low;
        state_next.one_count_high_byte = c1_high;
        state_next.zero_pin_prev = zero_count_pin;
        state_next.one_pin_prev = one_count_pin;
        state_next.ext0_active_prev = ext0_active;
        state_next.ext1_active_prev = ext1_active;

        set_zero_flag = c0_ovf;
        set_one_flag = (c1_ovf & ~split) | c0_hi_ovf;
        set_ext0 = state_reg.timer_run_and_flag_control[timer_pkg::TC_EXT0_TYPE]
            ? (ext0_active & ~state_reg.ext0_active_prev) : ext0_active;
        set_ext1 = state_reg.timer_run_and_flag_control[timer_pkg::TC_EXT1_TYPE]
            ? (ext1_active & ~state_reg.ext1_active_prev) : ext1_active;

        // Write completes once both address and data are held
        wr_fire = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
        if (wr_fire) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = mapped(state_reg.wr_index) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
            // Software load beats a count in the same cycle
            if (state_reg.wr_lane0) begin
                case (state_reg.wr_index)
                    timer_pkg::IDX_TIMER_RUN_AND_FLAG_CONTROL:
                        state_next.timer_run_and_flag_control = state_reg.wr_byte;
                    timer_pkg::IDX_TIMER_MODE_SELECT_REGISTER:
                        state_next.timer_mode_select_register = state_reg.wr_byte;
                    timer_pkg::IDX_ZERO_COUNT_LOW_BYTE: state_next.zero_count_low_byte = state_reg.wr_byte;
                    timer_pkg::IDX_ONE_COUNT_LOW_BYTE: state_next.one_count_low_byte = state_reg.wr_byte;
                    timer_pkg::IDX_ZERO_COUNT_HIGH_BYTE: state_next.zero_count_high_byte = state_reg.wr_byte;
                    timer_pkg::IDX_ONE_COUNT_HIGH_BYTE: state_next.one_count_high_byte = state_reg.wr_byte;
                    timer_pkg::IDX_CLOCK_CHOICE_REGISTER:
                        state_next.clock_choice_register = state_reg.wr_byte[1:0];
                    timer_pkg::IDX_EXT_INTERRUPT_CONFIG_REGISTER:
                        state_next.ext_interrupt_config_register = state_reg.wr_byte[1:0];
                    timer_pkg::IDX_TIMER_INTERRUPT_ENABLE:
                        state_next.timer_interrupt_enable = state_reg.wr_byte[1:0];
                    default: state_next.bresp = timer_pkg::RESP_SLVERR;
                endcase
            end
        end

        // Vectoring clears overflow flags, and external flags only when edge typed
        if (zero_vector_ack) begin
            state_next.timer_run_and_flag_control[timer_pkg::TC_ZERO_OVERFLOW] = 1'b0;
        end
        if (one_vector_ack) begin
            state_next.timer_run_and_flag_control[timer_pkg::TC_ONE_OVERFLOW] = 1'b0;
        end
        if (ext0_vector_ack & state_reg.timer_run_and_flag_control[timer_pkg::TC_EXT0_TYPE]) begin
            state_next.timer_run_and_flag_control[timer_pkg::TC_EXT0_FLAG] = 1'b0;
        end
        if (ext1_vector_ack & state_reg.timer_run_and_flag_control[timer_pkg::TC_EXT1_TYPE]) begin
            state_next.timer_run_and_flag_control[timer_pkg::TC_EXT1_FLAG] = 1'b0;
        end

        // Sets come last so an event never loses to a clear
        if (set_zero_flag) begin
            state_next.timer_run_and_flag_control[timer_pkg::TC_ZERO_OVERFLOW] = 1'b1;
        end
        if (set_one_flag) begin
            state_next.timer_run_and_flag_control[timer_pkg::TC_ONE_OVERFLOW] = 1'b1;
        end
        if (set_ext0) begin
            state_next.timer_run_and_flag_control[timer_pkg::TC_EXT0_FLAG] = 1'b1;
        end
        if (set_ext1) begin
            state_next.timer_run_and_flag_control[timer_pkg::TC_EXT1_FLAG] = 1'b1;
        end

        if (awvalid & state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.wr_index = awaddr[timer_pkg::ADDR_W-1:2];
        end
        if (wvalid & state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.wr_byte = wdata[7:0];
            state_next.wr_lane0 = wstrb[0];
        end
        if (state_reg.bvalid & bready) begin
            state_next.bvalid = 1'b0;
        end
        // One write in flight: channels reopen only after the response
        state_next.awready = ~state_next.aw_held & ~state_next.bvalid;
        state_next.wready = ~state_next.w_held & ~state_next.bvalid;

        if (arvalid & state_reg.arready) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = {24'h000000, read_byte(araddr[timer_pkg::ADDR_W-1:2], state_reg)};
            state_next.rresp = mapped(araddr[timer_pkg::ADDR_W-1:2]) ? timer_pkg::RESP_OKAY
                : timer_pkg::RESP_SLVERR;
        end else if (state_reg.rvalid & rready) begin
            state_next.rvalid = 1'b0;
        end
        state_next.arready = ~state_next.rvalid;

        state_next.zero_irq = state_next.timer_run_and_flag_control[timer_pkg::TC_ZERO_OVERFLOW]
            & state_next.timer_interrupt_enable[timer_pkg::IEN_ZERO];
        state_next.one_irq = state_next.timer_run_and_flag_control[timer_pkg::TC_ONE_OVERFLOW]
            & state_next.timer_interrupt_enable[timer_pkg::IEN_ONE];
        state_next.ext0_irq = state_next.timer_run_and_flag_control[timer_pkg::TC_EXT0_FLAG];
        state_next.ext1_irq = state_next.timer_run_and_flag_control[timer_pkg::TC_EXT1_FLAG];
        // Consumers see timer one overflow even while the flag is withheld
        state_next.one_overflow_pulse = c1_ovf;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign awready = state_reg.awready;
    assign wready = state_reg.wready;
    assign bresp = state_reg.bresp;
    assign bvalid = state_reg.bvalid;
    assign arready = state_reg.arready;
    assign rdata = state_reg.rdata;
    assign rresp = state_reg.rresp;
    assign rvalid = state_reg.rvalid;
    assign zero_irq = state_reg.zero_irq;
    assign one_irq = state_reg.one_irq;
    assign ext0_irq = state_reg.ext0_irq;
    assign ext1_irq = state_reg.ext1_irq;
    assign one_overflow_pulse = state_reg.one_overflow_pulse;

endmodule

// File: testbench/dual_legacy_counter_timer_properties.sv
/* Port checks for the counter/timer: bus handshakes, reset state, ack clear.
   Assumes binding to dual_legacy_counter_timer. */
`timescale 1ns/10ps
module timer_port_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid, arready, rvalid, rready,
    input wire logic [31:0] rdata,
    input wire logic zero_vector_ack, zero_irq, ext0_vector_ack, ext0_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_r_byte; rvalid |-> rdata[31:8] == 24'h0; endproperty
    a_r_byte: assert property (p_r_byte) else $error("upper read bits set");
    property p_w_ans; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
    a_w_ans: assert property (p_w_ans) else $error("no write answer");
    property p_r_ans; arvalid && arready |=> rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("no read answer");
    property p_w_refuse; bvalid |-> !awready && !wready; endproperty
    a_w_refuse: assert property (p_w_refuse) else $error("write taken early");
    property p_r_refuse; rvalid |-> !arready; endproperty
    a_r_refuse: assert property (p_r_refuse) else $error("read taken early");
    property p_reset; !$past(rst_n) |-> awready && arready && !bvalid && !zero_irq; endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");
    property p_ack; zero_vector_ack |=> !zero_irq; endproperty
    a_ack: assert property (p_ack) else $error("ack left irq");
    cover property (bvalid && bready && bresp == 2'h0);
    cover property (zero_vector_ack ##1 !zero_irq);
    cover property (ext0_vector_ack && ext0_irq);
endmodule
bind dual_legacy_counter_timer timer_port_checker chk_u (.*);

// File: testbench/pin_source.sv
/* Stand-in for the external count and gate pins.
   Assumes the bench calls its tasks; pins idle high. */
`timescale 1ns/10ps
module pin_source (
    input wire logic mclk,
    output logic zero_count_pin,
    output logic one_count_pin,
    output logic ext_gate_input_zero,
    output logic ext_gate_input_one
);
    initial begin
        zero_count_pin = 1'b1;
        one_count_pin = 1'b1;
        ext_gate_input_zero = 1'b1;
        ext_gate_input_one = 1'b1;
    end
    // Each level lasts at least two cycles so every fall is sampled
    task fall0(input int n);
        repeat (n) begin
            @(posedge mclk) zero_count_pin <= 1'b0;
            repeat (2) @(posedge mclk);
            zero_count_pin <= 1'b1;
            repeat (2) @(posedge mclk);
        end
    endtask
    task zero_gate_bit(input logic v);
        @(posedge mclk) ext_gate_input_zero <= v;
    endtask
endmodule

// File: testbench/dual_legacy_counter_timer_test.sv
/* Self-checking bench: registers, counting modes, gating, flags.
   Assumes pin_source drives the count and gate pins. */
`timescale 1ns/10ps
module dual_legacy_counter_timer_test;
    logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, prescale_tick;
    logic awready, wready, bvalid, arready, rvalid, zero_count_pin, one_count_pin;
    logic ext_gate_input_zero, ext_gate_input_one, zero_vector_ack, one_vector_ack;
    logic ext0_vector_ack, ext1_vector_ack, zero_irq, one_irq, ext0_irq, ext1_irq, one_overflow_pulse;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_val;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rd_resp, wr_resp;
    int n_errors, total_checks;
    localparam CT = timer_pkg::IDX_TIMER_RUN_AND_FLAG_CONTROL;
    localparam MD = timer_pkg::IDX_TIMER_MODE_SELECT_REGISTER;
    localparam ZL = timer_pkg::IDX_ZERO_COUNT_LOW_BYTE;
    localparam ZH = timer_pkg::IDX_ZERO_COUNT_HIGH_BYTE;
    localparam CK = timer_pkg::IDX_CLOCK_CHOICE_REGISTER;
    localparam EX = timer_pkg::IDX_EXT_INTERRUPT_CONFIG_REGISTER;
    dual_legacy_counter_timer dut_u (.*);
    pin_source pins_u (.*);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [9:0] i, input logic [7:0] d);
        int k;
        k = 0;
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Each channel is released at the edge that takes it
        do begin
            @(posedge mclk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (((awvalid && !awready) || (wvalid && !wready)) && k < 40);
        do begin @(posedge mclk); k++; end while (!bvalid && k < 40);
        wr_resp = bresp;
        if (k >= 40) begin n_errors++; wrap_up; end
    endtask
    task rd(input logic [9:0] i);
        int k;
        k = 0;
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        do begin @(posedge mclk); k++; end while (!arready && k < 40);
        arvalid <= 1'b0;
        do begin @(posedge mclk); k++; end while (!rvalid && k < 40);
        rd_val = rdata;
        rd_resp = rresp;
        if (k >= 40) begin n_errors++; wrap_up; end
    endtask
    task ack(input bit tmr);
        @(posedge mclk);
        if (tmr) zero_vector_ack <= 1'b1; else ext0_vector_ack <= 1'b1;
        @(posedge mclk);
        zero_vector_ack <= 1'b0;
        ext0_vector_ack <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task t_regs;
        rd(CT); chk("control reset", rd_val, 32'h0);
        wr(CT, 8'h05);
        wstrb <= 4'h0;
        wr(CT, 8'h50);
        wstrb <= 4'h1;
        rd(CT); chk("control types", rd_val, 32'h5);
        rd(10'h3ff); chk("unmapped resp", rd_resp, 2'h2);
        wr(10'h3ff, 8'h00); chk("unmapped write", wr_resp, 2'h2);
        $display("t_regs done");
    endtask
    // External edges give an exact count, so wrap results are exact
    task t_wrap(input logic [1:0] m, input logic [7:0] lo, hi, elo, ehi, input int n);
        wr(CT, 8'h00);
        wr(timer_pkg::IDX_TIMER_INTERRUPT_ENABLE, 8'h01);
        wr(ZL, lo);
        wr(ZH, hi);
        wr(MD, {6'h01, m});
        wr(CT, 8'h10);
        pins_u.fall0(n);
        repeat (3) @(posedge mclk);
        chk("overflow irq", zero_irq, 1'b1);
        rd(CT); chk("flag and run", rd_val, 32'h30);
        rd(ZL); chk("low byte", rd_val, {24'h0, elo});
        rd(ZH); chk("high byte", rd_val, {24'h0, ehi});
        $display("t_wrap mode %0d done", m);
    endtask
    task t_internal;
        int k;
        wr(CT, 8'h00);
        wr(CK, 8'h00);
        wr(ZL, 8'hfe);
        wr(ZH, 8'hff);
        wr(MD, 8'h01);
        wr(CT, 8'h10);
        repeat (10) @(posedge mclk);
        chk("prescaled hold", zero_irq, 1'b0);
        prescale_tick <= 1'b1;
        @(posedge mclk) prescale_tick <= 1'b0;
        rd(ZL); chk("prescaled tick", rd_val, 32'hff);
        wr(CK, 8'h01);
        k = 0;
        while (zero_irq !== 1'b1 && k < 20) begin @(posedge mclk); k++; end
        chk("system clock irq", zero_irq, 1'b1);
        $display("t_internal done");
    endtask
    task t_gate;
        wr(CT, 8'h00);
        wr(EX, 8'h01);
        wr(ZL, 8'h00);
        wr(MD, 8'h0d);
        wr(CT, 8'h10);
        pins_u.fall0(2);
        pins_u.zero_gate_bit(1'b0);
        pins_u.fall0(3);
        repeat (3) @(posedge mclk);
        rd(ZL); chk("gated count", rd_val, 32'h2);
        $display("t_gate done");
    endtask
    task t_ext;
        wr(CT, 8'h01);
        chk("edge idle", ext0_irq, 1'b0);
        pins_u.zero_gate_bit(1'b1);
        repeat (3) @(posedge mclk);
        chk("edge flag", ext0_irq, 1'b1);
        ack(1'b0);
        chk("edge ack", ext0_irq, 1'b0);
        wr(CT, 8'h00);
        ack(1'b0);
        chk("level kept", ext0_irq, 1'b1);
        $display("t_ext done");
    endtask
    // Split high counter runs on timer one's run bit and raises timer one's request
    task t_split;
        wr(CT, 8'h00);
        wr(ZH, 8'hff);
        wr(MD, 8'h03);
        wr(timer_pkg::IDX_TIMER_INTERRUPT_ENABLE, 8'h02);
        wr(CT, 8'h40);
        repeat (3) @(posedge mclk);
        chk("split high irq", one_irq, 1'b1);
        $display("t_split done");
    endtask
    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, arvalid, prescale_tick, zero_vector_ack, one_vector_ack} = 6'h0;
        {ext0_vector_ack, ext1_vector_ack, bready, rready} = 4'h3;
        {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'h1};
        n_errors = 0;
        total_checks = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs;
        t_wrap(2'h0, 8'hff, 8'hff, 8'he0, 8'h00, 1);
        t_wrap(2'h1, 8'hfe, 8'hff, 8'h00, 8'h00, 2);
        t_wrap(2'h2, 8'hfe, 8'hf0, 8'hf1, 8'hf0, 3);
        ack(1'b1);
        chk("vector clears", zero_irq, 1'b0);
        t_internal;
        t_gate;
        t_ext;
        t_split;
        wrap_up;
    end
endmodule
